//--- common/link_err_pkg.sv
package link_err_pkg;

  localparam int FLAG_W = 16;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 16'h0000;
  localparam int BIT_UNLOCK = 9;
  localparam int BIT_OVERRUN = 8;
  localparam int BIT_OVERFLOW = 7;
  localparam int BIT_SYNC_LOST = 6;
  localparam int BIT_RUN_DISP = 5;
  localparam int BIT_BAD_SYMBOL = 4;
  localparam int BIT_WORD_ALIGN = 3;
  localparam int BIT_START_DISP = 2;
  localparam int BIT_CRC = 1;
  localparam int BIT_SIGNAL_LOST = 0;

  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH_DEF = 8;
  // Smallest epoch is 8 bytes, two words.
  localparam int EPOCH_WORDS_DEF = 2;
  localparam int EPOCH_CNT_W = 32;

  typedef enum logic {PH_COPY, PH_INSERT} phase_t;

  // Receiver pins; all are outside the clk domain and are synchronised as one bundle.
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic valid;
    logic bof;
    logic crc_bad;
    logic run_disp;
    logic bad_symbol;
    logic word_align;
    logic start_disp;
    logic pll_locked;
    logic sync_detect;
    logic signal_present;
  } link_pins_t;

  // Synchroniser reset value: the health pins read good, so leaving reset reports no fault.
  localparam link_pins_t PINS_RESET = link_pins_t'({{DATA_W{1'b0}}, 7'h00, 3'h7});

endpackage

//--- design/stream_fifo.sv
`timescale 1ns/10ps
module stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("stream_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic load;

  assign push = in_valid & in_ready;
  // The output register holds one word beyond the memory, so the stage always drains.
  assign load = (count_reg != '0) & (~out_valid | out_ready);

  always_comb
  begin
    count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b1;
    end
    else if (flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (load)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      in_ready <= (count_next < DEPTH_C);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (flush)
    begin
      out_valid <= 1'b0;
    end
    else if (load)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr_reg];
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end

endmodule // stream_fifo

//--- design/fiber_link_error_status.sv
// Behaviour
// - Bit 9 sets while receive clock recovery is unlocked.
// - Bit 8 sets when transmit data arrives but the transmit FIFO cannot take it.
// - Bit 7 sets when a received word is dropped on receive FIFO overflow.
// - Bit 6 sets while the receiver sees no synchronisation signal.
// - Bits 5, 4, 3, 2 flag disparity, bad symbol, alignment, start disparity.
// - Bit 1 sets on a receive CRC failure.
// - Bit 0 sets while no optical signal is received.
// - A summary bit shows that the detailed error register holds a flag.
// - Error clear drops the summary, but it stays while a fault persists.
// - Link clear empties both transmit and receive FIFOs.
// - Link clear restarts the epoch and returns append to its copy phase.
// - CRC checking and transmit CRC happen only while check enable is on.
`timescale 1ns/10ps
module fiber_link_error_status
  import link_err_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter int EPOCH_WORDS = EPOCH_WORDS_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic link_clk,
  input wire link_pins_t rx_pins,
  input wire logic check_enable_on,
  input wire logic append_mode,
  input wire logic error_clear,
  input wire logic link_clear,
  input wire logic in_valid,
  input wire logic [DATA_W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [DATA_W-1:0] out_data,
  input wire logic out_ready,
  output logic [DATA_W-1:0] tx_data,
  output logic tx_valid,
  output logic tx_crc_insert,
  output logic tx_epoch_end,
  output logic append_insert_phase,
  output logic [FLAG_W-1:0] link_error_flags,
  output logic link_error_summary_bit
);

  if (EPOCH_WORDS < 2)
  begin : g_bad_epoch
    $error("EPOCH_WORDS must be at least 2");
  end

  link_pins_t pins_s1_reg;
  link_pins_t pins_s2_reg;
  logic [2:0] lclk_reg;
  logic link_rise;
  logic rx_push;
  logic rx_in_ready;
  logic tx_out_valid;
  logic [DATA_W-1:0] tx_out_data;
  logic tx_pop;
  logic [FLAG_W-1:0] cond;
  logic [FLAG_W-1:0] flags_next;
  logic [EPOCH_CNT_W-1:0] epoch_cnt_reg;
  phase_t phase_reg;

  // The last word of an epoch is decoded for the marker and for the counter wrap alike.
  function automatic logic epoch_last(input logic [EPOCH_CNT_W-1:0] cnt);
    return (cnt == EPOCH_CNT_W'(EPOCH_WORDS - 1));
  endfunction

  // Link clock and pins share the same two-stage synchroniser depth, so data stays
  // aligned to the detected edge; the link period is far longer than clk.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // A zero reset value would read as a dead link and latch three false flags.
      pins_s1_reg <= PINS_RESET;
      pins_s2_reg <= PINS_RESET;
      lclk_reg <= 3'h0;
    end
    else
    begin
      pins_s1_reg <= rx_pins;
      pins_s2_reg <= pins_s1_reg;
      lclk_reg <= {lclk_reg[1:0], link_clk};
    end
  end

  assign link_rise = lclk_reg[1] & ~lclk_reg[2];
  assign rx_push = link_rise & pins_s2_reg.valid;
  // In append mode local words go out only in the insert window after a BOF.
  assign tx_pop = link_rise & tx_out_valid & (~append_mode | (phase_reg == PH_INSERT));

  stream_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .rstn(rstn),
    .flush(link_clear),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .in_data(pins_s2_reg.data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  stream_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(clk),
    .rstn(rstn),
    .flush(link_clear),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_data),
    .out_valid(tx_out_valid),
    .out_ready(tx_pop),
    .out_data(tx_out_data)
  );

  always_comb
  begin
    cond = '0;
    cond[BIT_UNLOCK] = ~pins_s2_reg.pll_locked;
    cond[BIT_OVERRUN] = in_valid & ~in_ready;
    cond[BIT_OVERFLOW] = rx_push & ~rx_in_ready;
    cond[BIT_SYNC_LOST] = ~pins_s2_reg.sync_detect;
    cond[BIT_RUN_DISP] = link_rise & pins_s2_reg.run_disp;
    cond[BIT_BAD_SYMBOL] = link_rise & pins_s2_reg.bad_symbol;
    cond[BIT_WORD_ALIGN] = link_rise & pins_s2_reg.word_align;
    cond[BIT_START_DISP] = link_rise & pins_s2_reg.start_disp;
    cond[BIT_CRC] = link_rise & pins_s2_reg.crc_bad & check_enable_on;
    cond[BIT_SIGNAL_LOST] = ~pins_s2_reg.signal_present;
    // A new or lasting cause beats the clear in the same cycle.
    flags_next = cond | (link_error_flags & ~{FLAG_W{error_clear}});
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      link_error_flags <= FLAGS_RESET;
      link_error_summary_bit <= 1'b0;
    end
    else
    begin
      link_error_flags <= flags_next;
      link_error_summary_bit <= |flags_next;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_data <= '0;
      tx_valid <= 1'b0;
      tx_epoch_end <= 1'b0;
      tx_crc_insert <= 1'b0;
    end
    else
    begin
      tx_crc_insert <= check_enable_on;
      if (link_clear)
      begin
        tx_valid <= 1'b0;
        tx_epoch_end <= 1'b0;
      end
      else if (link_rise)
      begin
        tx_valid <= tx_pop;
        tx_epoch_end <= tx_pop & epoch_last(epoch_cnt_reg);
        if (tx_pop)
        begin
          tx_data <= tx_out_data;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      epoch_cnt_reg <= '0;
      phase_reg <= PH_COPY;
    end
    else if (link_clear)
    begin
      epoch_cnt_reg <= '0;
      phase_reg <= PH_COPY;
    end
    else if (tx_pop && epoch_last(epoch_cnt_reg))
    begin
      epoch_cnt_reg <= '0;
      phase_reg <= PH_COPY;
    end
    else
    begin
      if (tx_pop)
      begin
        epoch_cnt_reg <= epoch_cnt_reg + 1'b1;
      end
      case (phase_reg)
        PH_COPY:
        begin
          if (link_rise && pins_s2_reg.bof)
          begin
            phase_reg <= PH_INSERT;
          end
        end
        PH_INSERT:
        begin
          phase_reg <= PH_INSERT;
        end
        default:
        begin
          phase_reg <= PH_COPY;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      append_insert_phase <= 1'b0;
    end
    else
    begin
      append_insert_phase <= (phase_reg == PH_INSERT);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_clear_while_dark;
    error_clear && !pins_s2_reg.signal_present;
  endsequence

  sequence s_link_flush;
    link_clear ##1 1'b1;
  endsequence

  a_unlock_flag: assert property (
    !pins_s2_reg.pll_locked |=> link_error_flags[BIT_UNLOCK])
    else $error("unlock flag missing");
  a_overrun_flag: assert property (
    in_valid && !in_ready |=> link_error_flags[BIT_OVERRUN])
    else $error("overrun flag missing");
  a_overflow_flag: assert property (
    rx_push && !rx_in_ready |=> link_error_flags[BIT_OVERFLOW])
    else $error("overflow flag missing");
  a_sync_flag: assert property (
    !pins_s2_reg.sync_detect |=> link_error_flags[BIT_SYNC_LOST])
    else $error("sync lost flag missing");
  a_align_flag: assert property (
    link_rise && pins_s2_reg.word_align |=> link_error_flags[BIT_WORD_ALIGN])
    else $error("alignment flag missing");
  a_crc_gated: assert property (
    $rose(link_error_flags[BIT_CRC]) |-> $past(check_enable_on))
    else $error("crc flag set while checking off");
  a_crc_flag: assert property (
    cond[BIT_CRC] |=> link_error_flags[BIT_CRC] && link_error_summary_bit)
    else $error("crc flag missing");
  a_signal_flag: assert property (
    !pins_s2_reg.signal_present |=> link_error_flags[BIT_SIGNAL_LOST])
    else $error("signal lost flag missing");
  a_summary_tracks: assert property (
    link_error_summary_bit == (link_error_flags != '0))
    else $error("summary disagrees with flags");
  a_clear_holds: assert property (
    s_clear_while_dark |=> link_error_summary_bit)
    else $error("summary cleared while fault persists");
  a_flags_latch: assert property (
    link_error_flags[BIT_SYNC_LOST] && !error_clear |=> link_error_flags[BIT_SYNC_LOST])
    else $error("flag dropped without clear");
  a_fifo_flush: assert property (
    s_link_flush |-> !out_valid && in_ready && !tx_valid)
    else $error("fifo not flushed by link clear");
  a_phase_reset: assert property (
    link_clear |=> ##1 !append_insert_phase && epoch_cnt_reg == '0)
    else $error("epoch or phase not reset");

endmodule // fiber_link_error_status

//--- dv/far_end_model.sv
`timescale 1ns/10ps
module far_end_model
  import link_err_pkg::*;
(
  input logic run,
  output logic link_clk,
  output link_pins_t pins
);
  initial
  begin
    link_clk = 1'b0;
    pins = '0;
    pins.pll_locked = 1'b1;
    pins.sync_detect = 1'b1;
    pins.signal_present = 1'b1;
  end
  // The link clock stands still while the bench stops the link.
  always #80 if (run) link_clk = ~link_clk;
  task automatic level(input int i, input logic v);
    if (i == 0) pins.pll_locked = v;
    else if (i == 1) pins.sync_detect = v;
    else pins.signal_present = v;
  endtask
  // Data turns to its inverse once released, so a stale word never looks valid.
  task automatic send(input logic [DATA_W-1:0] d, input logic b, input logic [4:0] ev);
    @(negedge link_clk);
    pins.data = d;
    pins.valid = 1'b1;
    pins.bof = b;
    {pins.crc_bad, pins.run_disp, pins.bad_symbol, pins.word_align, pins.start_disp} = ev;
    @(negedge link_clk);
    pins.data = ~d;
    pins.valid = 1'b0;
    pins.bof = 1'b0;
    {pins.crc_bad, pins.run_disp, pins.bad_symbol, pins.word_align, pins.start_disp} = '0;
  endtask
endmodule // far_end_model

//--- dv/fiber_link_error_status_tb.sv
`timescale 1ns/10ps
module fiber_link_error_status_tb
  import link_err_pkg::*;
();
  logic clk = 1'b0, rstn = 1'b0, run = 1'b1, link_clk, ce = 1'b1, am = 1'b0;
  logic ec = 1'b0, lc = 1'b0, in_valid = 1'b0, in_ready, out_valid, out_ready = 1'b0;
  logic [DATA_W-1:0] in_data = '0, out_data, tx_data, d;
  logic tx_valid, tx_crc, tx_ee, aip, sum;
  logic [FLAG_W-1:0] fl;
  link_pins_t pins;
  logic [DATA_W-1:0] rxq[$], txq[$];
  int failures = 0, samples_checked = 0, cyc = 0, ep = 0;
  int lb[3] = '{BIT_UNLOCK, BIT_SYNC_LOST, BIT_SIGNAL_LOST};
  integer seed = 22060;
  bit hold = 1'b0, ovr;
  always #5 clk = ~clk;
  far_end_model FE (.run(run), .link_clk(link_clk), .pins(pins));
  fiber_link_error_status #(.FIFO_DEPTH(8), .EPOCH_WORDS(2)) DUT (.clk(clk), .rstn(rstn),
    .link_clk(link_clk), .rx_pins(pins), .check_enable_on(ce), .append_mode(am),
    .error_clear(ec), .link_clear(lc), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_crc_insert(tx_crc), .tx_epoch_end(tx_ee),
    .append_insert_phase(aip), .link_error_flags(fl), .link_error_summary_bit(sum));
  task automatic cmp(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic flags(input logic [FLAG_W-1:0] e);
    cmp(DATA_W'(fl), DATA_W'(e));
    cmp(DATA_W'(sum), DATA_W'(|e));
  endtask
  task automatic pulse(input bit l);
    if (l) lc <= 1'b1; else ec <= 1'b1;
    @(posedge clk);
    lc <= 1'b0;
    ec <= 1'b0;
    @(posedge clk);
  endtask
  task automatic burst(input int n);
    ovr = 1'b0;
    repeat (n)
    begin
      in_valid <= 1'b1;
      in_data <= $random(seed);
      @(posedge clk);
      if (in_ready === 1'b1) txq.push_back(in_data); else ovr = 1'b1;
    end
    in_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      end_of_test();
    end
    out_ready <= hold ? 1'b0 : 1'($random(seed));
    if (out_valid === 1'b1 && out_ready === 1'b1)
      cmp(out_data, rxq.size() > 0 ? rxq.pop_front() : ~out_data);
  end
  always @(posedge link_clk)
    if (tx_valid === 1'b1)
    begin
      cmp(tx_data, txq.size() > 0 ? txq.pop_front() : ~tx_data);
      cmp(DATA_W'(tx_ee), DATA_W'(ep % 2));
      ep++;
    end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    flags('0);
    for (int i = 0; i < 3; i++)
    begin
      FE.level(i, 1'b0);
      repeat (6) @(posedge clk);
      pulse(0);
      flags(FLAG_W'(1) << lb[i]);
      FE.level(i, 1'b1);
      repeat (6) @(posedge clk);
      flags(FLAG_W'(1) << lb[i]);
      pulse(0);
      flags('0);
    end
    for (int i = 0; i < 6; i++)
    begin
      ce <= (i != 5);
      d = $random(seed);
      rxq.push_back(d);
      FE.send(d, 1'b0, (i < 5) ? 5'(1 << i) : 5'h10);
      repeat (4) @(posedge clk);
      flags((i == 5) ? '0 : (i == 4) ? 16'h0002 : 16'h0004 << i);
      cmp(DATA_W'(tx_crc), DATA_W'(i != 5));
      pulse(0);
    end
    repeat (20) @(posedge clk);
    hold = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      d = $random(seed);
      if (i < 9) rxq.push_back(d);
      FE.send(d, 1'b0, 5'h00);
    end
    repeat (4) @(posedge clk);
    flags(16'h0080);
    hold = 1'b0;
    repeat (40) @(posedge clk);
    cmp(rxq.size(), 0);
    pulse(0);
    burst(6);
    repeat (150) @(posedge clk);
    cmp(txq.size(), 0);
    hold = 1'b1;
    FE.send($random(seed), 1'b0, 5'h00);
    run = 1'b0;
    burst(12);
    repeat (2) @(posedge clk);
    cmp(DATA_W'(ovr), 32'h1);
    flags(16'h0100);
    pulse(1);
    ep = 0;
    txq.delete();
    cmp(DATA_W'(in_ready), 32'h1);
    hold = 1'b0;
    run = 1'b1;
    repeat (60) @(posedge clk);
    pulse(0);
    flags('0);
    am <= 1'b1;
    burst(2);
    repeat (80) @(posedge clk);
    cmp(txq.size(), 2);
    for (int i = 0; i < 2; i++)
    begin
      d = $random(seed);
      rxq.push_back(d);
      FE.send(d, 1'b1, 5'h00);
      cmp(DATA_W'(aip), 32'h1);
      repeat (60) @(posedge clk);
    end
    cmp(txq.size(), 0);
    pulse(1);
    repeat (2) @(posedge clk);
    cmp(DATA_W'(aip), 32'h0);
    end_of_test();
  end
endmodule // fiber_link_error_status_tb
